// ==== qenc_pkg.sv ====
// constants and types for the quadrature encoder input stage
// Function
// - The rotation sense setting makes forward clockwise at 0 and counterclockwise at 1, and resets to 1.
// - The line count setting accepts 0 to 4096 and resets to 1024.
// - The line count is raw lines per revolution and the block counts every A and B edge, four per line.
// - One decoded position serves orientation, encoder feedback and vector control together.
// - The decoded position and index mark support stopping the spindle at a chosen angle.
package qenc_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // glitch filter: a level must hold this long before it is believed
   localparam int FILTER_TIME_NS = 40;
   localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILTER_CNT_W = $clog2(FILTER_CYCLES + 1);
   localparam int LINE_W = 13;
   localparam int POS_W = 14;
   localparam int EDGES_PER_LINE_LOG2 = 2;
   localparam logic [LINE_W-1:0] LINE_COUNT_RESET = 13'h0400;
   localparam logic [LINE_W-1:0] LINE_COUNT_MAX = 13'h1000;
   localparam logic SENSE_RESET = 1'b1;
   localparam logic SENSE_CW = 1'b0;
   localparam logic [POS_W-1:0] POS_ALL_ONES = 14'h3fff;
   // state vector is {a, b}; the listed order is the gray path with b leading
   typedef enum logic [1:0]
   {
      QS_00 = 2'b00,
      QS_01 = 2'b01,
      QS_11 = 2'b11,
      QS_10 = 2'b10
   } quad_state_t;
endpackage : qenc_pkg

// ==== phase_receiver.sv ====
// one encoder phase receiver: pair check and glitch filter
`timescale 1ns/1ps
module phase_receiver
   import qenc_pkg::*;
(
   input wire logic ref_clk, // system clock
   input wire logic rst, // synchronous reset, high
   input wire logic diff_mode, // 1: differential pair, 0: single-ended
   input wire logic true_in, // true line of the phase
   input wire logic inverse_in, // inverse line, unused when single-ended
   output logic level_out, // filtered phase level
   output logic fault_out // pair lines agree (broken or open line)
);
   logic [FILTER_CNT_W-1:0] cnt_ff;
   logic pair_bad;

   // an open inverse line reads the same as the true line
   assign pair_bad = diff_mode && (true_in == inverse_in);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         cnt_ff <= '0;
         level_out <= 1'b0;
      end
      else if (true_in == level_out)
         cnt_ff <= '0;
      else if (cnt_ff == FILTER_CNT_W'(FILTER_CYCLES - 1))
      begin
         cnt_ff <= '0;
         level_out <= true_in;
      end
      else
         cnt_ff <= cnt_ff + 1'b1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         fault_out <= 1'b0;
      else
         fault_out <= pair_bad;
   end
endmodule : phase_receiver

// ==== quadrature_encoder_input.sv ====
// quadrature decoder with rotation sense, line count and index capture
`timescale 1ns/1ps
module quadrature_encoder_input
   import qenc_pkg::*;
(
   input wire logic ref_clk, // system clock, 100 MHz
   input wire logic rst, // synchronous reset, high
   input wire logic diff_mode, // 1: differential receivers, 0: single-ended
   input wire logic phase_a_in, // encoder phase a
   input wire logic phase_a_inverse_in, // encoder phase a inverse
   input wire logic phase_b_in, // encoder phase b
   input wire logic phase_b_inverse_in, // encoder phase b inverse
   input wire logic index_in, // encoder index
   input wire logic index_inverse_in, // encoder index inverse
   input wire logic setting_wr, // one-cycle strobe loading rotation sense and an in-range line count
   input wire logic rotation_sense_wdata, // new rotation sense
   input wire logic [LINE_W-1:0] line_count_wdata, // new line count
   output logic rotation_sense_select, // current rotation sense
   output logic [LINE_W-1:0] encoder_line_count, // current line count
   output logic setting_reject, // pulse: line count above range was ignored
   output logic [POS_W-1:0] position, // shaft position in edges
   output logic direction_fwd, // last move was forward
   output logic count_strobe, // pulse: position moved
   output logic index_strobe, // pulse: index rising edge seen
   output logic [POS_W-1:0] index_position, // position at last index
   output logic index_seen, // an index has been seen since reset
   output logic phase_error, // pulse: a and b changed together
   output logic signal_fault // a receiver pair is broken
);
   logic a_lvl;
   logic b_lvl;
   logic z_lvl;
   logic a_flt;
   logic b_flt;
   logic z_flt;
   quad_state_t state_ff;
   quad_state_t cur_state;
   logic primed_ff;
   logic z_prev_ff;
   logic a_leads;
   logic b_leads;
   logic mv_fwd;
   logic mv_rev;
   logic line_ok;
   logic [POS_W-1:0] top_pos;
   logic [POS_W+1:0] span;

   // next state when a leads; b leading walks the same ring backwards
   function automatic quad_state_t a_lead_next(input quad_state_t s);
      unique case (s)
         QS_00: a_lead_next = QS_10;
         QS_10: a_lead_next = QS_11;
         QS_11: a_lead_next = QS_01;
         QS_01: a_lead_next = QS_00;
      endcase
   endfunction : a_lead_next

   phase_receiver rx_a
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .diff_mode(diff_mode),
      .true_in(phase_a_in),
      .inverse_in(phase_a_inverse_in),
      .level_out(a_lvl),
      .fault_out(a_flt)
   );

   phase_receiver rx_b
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .diff_mode(diff_mode),
      .true_in(phase_b_in),
      .inverse_in(phase_b_inverse_in),
      .level_out(b_lvl),
      .fault_out(b_flt)
   );

   phase_receiver rx_z
   (
      .ref_clk(ref_clk),
      .rst(rst),
      .diff_mode(diff_mode),
      .true_in(index_in),
      .inverse_in(index_inverse_in),
      .level_out(z_lvl),
      .fault_out(z_flt)
   );

   assign line_ok = (line_count_wdata <= LINE_COUNT_MAX);

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         rotation_sense_select <= SENSE_RESET;
      else if (setting_wr)
         rotation_sense_select <= rotation_sense_wdata;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         encoder_line_count <= LINE_COUNT_RESET;
      else if (setting_wr && line_ok)
         encoder_line_count <= line_count_wdata;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         setting_reject <= 1'b0;
      else
         setting_reject <= setting_wr && !line_ok;
   end

   // four edges per line; zero lines leaves the count free-running over 14 bits
   assign span = {1'b0, encoder_line_count, {EDGES_PER_LINE_LOG2{1'b0}}};
   assign top_pos = (encoder_line_count == '0) ? POS_ALL_ONES : POS_W'(span - 1'b1);

   assign cur_state = quad_state_t'({a_lvl, b_lvl});
   assign a_leads = primed_ff && (cur_state == a_lead_next(state_ff));
   assign b_leads = primed_ff && (state_ff == a_lead_next(cur_state));
   // clockwise from the shaft end is a leading a
   assign mv_fwd = (rotation_sense_select == SENSE_CW) ? a_leads : b_leads;
   assign mv_rev = (rotation_sense_select == SENSE_CW) ? b_leads : a_leads;

   // first sample after reset only primes the decoder, it must not count
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state_ff <= QS_00;
         primed_ff <= 1'b0;
      end
      else
      begin
         state_ff <= cur_state;
         primed_ff <= 1'b1;
      end
   end

   // a settings load clears the position so it never sits above a new top
   always_ff @(posedge ref_clk)
   begin
      if (rst || setting_wr)
         position <= '0;
      else if (mv_fwd)
         position <= (position == top_pos) ? '0 : position + 1'b1;
      else if (mv_rev)
         position <= (position == '0) ? top_pos : position - 1'b1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         direction_fwd <= 1'b1;
         count_strobe <= 1'b0;
      end
      else
      begin
         count_strobe <= !setting_wr && (mv_fwd || mv_rev);
         if (!setting_wr && (mv_fwd || mv_rev))
            direction_fwd <= mv_fwd;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         phase_error <= 1'b0;
      else
         phase_error <= primed_ff && (cur_state != state_ff) && !a_leads && !b_leads;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         signal_fault <= 1'b0;
      else
         signal_fault <= a_flt || b_flt || z_flt;
   end

   // index capture gives orientation a fixed angular reference
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         z_prev_ff <= 1'b0;
         index_strobe <= 1'b0;
         index_position <= '0;
         index_seen <= 1'b0;
      end
      else
      begin
         z_prev_ff <= z_lvl;
         index_strobe <= z_lvl && !z_prev_ff;
         if (z_lvl && !z_prev_ff)
         begin
            index_position <= position;
            index_seen <= 1'b1;
         end
      end
   end

   a_sense_reset: assert property (@(posedge ref_clk)
      $past(rst) && !rst |-> rotation_sense_select == SENSE_RESET)
      else $error("rotation sense not at reset value");

   a_line_reset: assert property (@(posedge ref_clk)
      $past(rst) && !rst |-> encoder_line_count == LINE_COUNT_RESET)
      else $error("line count not at reset value");

   a_line_reject: assert property (@(posedge ref_clk) disable iff (rst)
      setting_wr && line_count_wdata > LINE_COUNT_MAX
      |=> setting_reject && $stable(encoder_line_count))
      else $error("out of range line count was taken");

   a_sense_dir: assert property (@(posedge ref_clk) disable iff (rst)
      !setting_wr && a_leads |=> count_strobe && (direction_fwd == !$past(rotation_sense_select)))
      else $error("direction does not follow rotation sense");

   a_span_top: assert property (@(posedge ref_clk) disable iff (rst)
      encoder_line_count != '0 |-> 16'(top_pos) + 16'd1 == 16'(encoder_line_count) * 16'd4)
      else $error("count span is not four edges per line");

   a_wrap_fwd: assert property (@(posedge ref_clk) disable iff (rst)
      !setting_wr && mv_fwd && position == top_pos |=> position == '0 ##1 1'b1)
      else $error("forward count did not wrap to zero");

   a_wrap_rev: assert property (@(posedge ref_clk) disable iff (rst)
      !setting_wr && mv_rev && position == '0 |=> position == $past(top_pos))
      else $error("reverse count did not wrap to top");

   a_strobe_moves: assert property (@(posedge ref_clk) disable iff (rst)
      count_strobe |-> position != $past(position))
      else $error("count strobe without a position change");

   a_index_take: assert property (@(posedge ref_clk) disable iff (rst)
      z_lvl && !z_prev_ff |=> index_strobe && index_seen && index_position == $past(position))
      else $error("index position not captured");
endmodule : quadrature_encoder_input

// ==== shaft_encoder_model.sv ====
// behavioural shaft encoder: quadrature phases, index mark, inverse lines
`timescale 1ns/1ps
module shaft_encoder_model
#(
   parameter int LINES = 1000, // lines per revolution
   parameter int QTR = 8 // cycles per quarter period
)
(
   input wire logic ref_clk, // system clock
   output logic phase_a, // phase a
   output logic phase_a_n, // phase a inverse
   output logic phase_b, // phase b
   output logic phase_b_n, // phase b inverse
   output logic index, // index mark
   output logic index_n // index inverse
);
   int count = 0;
   logic [1:0] ab;
   // an open inverse line reads the same as its true line
   logic open_inv = 1'b0;
   initial index = 1'b0;
   // clockwise walks 00,10,11,01 so a leads b by a quarter cycle
   always_comb
   begin
      case (count % 4)
         0: ab = 2'b00;
         1: ab = 2'b10;
         2: ab = 2'b11;
         default: ab = 2'b01;
      endcase
   end
   assign phase_a = ab[1];
   assign phase_b = ab[0];
   assign phase_a_n = open_inv ? ab[1] : ~ab[1];
   assign phase_b_n = ~ab[0];
   assign index_n = ~index;
   // every edge interval is exactly QTR cycles, well inside the tolerance
   task automatic step(input bit cw);
      @(posedge ref_clk);
      #1;
      count = cw ? (count + 1) % (4 * LINES) : (count + 4 * LINES - 1) % (4 * LINES);
      index = 1'b0;
      if (count == 0)
      begin
         // mark raised late so it never races the phase edge
         repeat (3) @(posedge ref_clk);
         #1;
         index = 1'b1;
         repeat (QTR - 4) @(posedge ref_clk);
      end
      else
         repeat (QTR - 1) @(posedge ref_clk);
   endtask : step
   // a and b flip together, as a damaged encoder would
   task automatic skip();
      @(posedge ref_clk);
      #1;
      count = (count + 2) % (4 * LINES);
      index = 1'b0;
      repeat (QTR - 1) @(posedge ref_clk);
   endtask : skip
   task automatic open_line(input bit o);
      open_inv = o;
   endtask : open_line
endmodule : shaft_encoder_model

// ==== tb.sv ====
// self-checking testbench for the quadrature encoder input stage
`timescale 1ns/1ps
module tb;
   import qenc_pkg::*;
   logic ref_clk = 1'b0;
   logic rst;
   logic diff_mode;
   logic setting_wr;
   logic rotation_sense_wdata;
   logic [LINE_W-1:0] line_count_wdata;
   logic a, a_n, b, b_n, z, z_n, sense, rej_out, fwd, cstb, istb, iseen, perr, sfault;
   logic [LINE_W-1:0] lines;
   logic [POS_W-1:0] pos, ipos;
   logic rej;
   int errors = 0;
   int n_tests = 0;
   int n_strobe = 0;
   int n_index = 0;
   int n_perr = 0;
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      if (cstb === 1'b1)
         n_strobe++;
      if (istb === 1'b1)
         n_index++;
      if (perr === 1'b1)
         n_perr++;
   end
   shaft_encoder_model #(.LINES(1000), .QTR(8)) enc (.ref_clk(ref_clk), .phase_a(a),
      .phase_a_n(a_n), .phase_b(b), .phase_b_n(b_n), .index(z), .index_n(z_n));
   quadrature_encoder_input dut (.ref_clk(ref_clk), .rst(rst), .diff_mode(diff_mode),
      .phase_a_in(a), .phase_a_inverse_in(a_n), .phase_b_in(b), .phase_b_inverse_in(b_n),
      .index_in(z), .index_inverse_in(z_n), .setting_wr(setting_wr),
      .rotation_sense_wdata(rotation_sense_wdata), .line_count_wdata(line_count_wdata),
      .rotation_sense_select(sense), .encoder_line_count(lines), .setting_reject(rej_out),
      .position(pos), .direction_fwd(fwd), .count_strobe(cstb), .index_strobe(istb),
      .index_position(ipos), .index_seen(iseen), .phase_error(perr), .signal_fault(sfault));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize
   // reject pulse stands one cycle, so it is sampled right after the taking edge;
   // one idle edge follows so back to back writes never retoggle the strobe at once
   task automatic wr(input logic s, input logic [LINE_W-1:0] n);
      setting_wr = 1'b1;
      rotation_sense_wdata = s;
      line_count_wdata = n;
      @(posedge ref_clk);
      #1;
      setting_wr = 1'b0;
      rej = rej_out;
      @(posedge ref_clk);
      #1;
   endtask : wr
   task automatic settle();
      repeat (2) @(posedge ref_clk);
      #1;
   endtask : settle
   task automatic t_reset();
      check(sense, 1'b1);
      check(lines, 13'h0400);
      check(pos, 14'h0000);
      check(fwd, 1'b1);
      check(iseen, 1'b0);
      check(sfault, 1'b0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_sense(input logic s, input logic dm);
      diff_mode = dm;
      wr(s, 13'h0400);
      n_strobe = 0;
      repeat (4) enc.step(1'b1);
      settle();
      check(pos, s ? 14'h0ffc : 14'h0004);
      check(fwd, !s);
      repeat (4) enc.step(1'b0);
      settle();
      check(pos, 14'h0000);
      check(fwd, s);
      check(n_strobe, 8);
      check(perr, 1'b0);
      $display("test sense done");
   endtask : t_sense
   task automatic t_reject();
      wr(1'b0, 13'h1001);
      check(rej, 1'b1);
      check(lines, 13'h0400);
      check(sense, 1'b0);
      wr(1'b1, 13'h1000);
      check(rej, 1'b0);
      check(lines, 13'h1000);
      $display("test reject done");
   endtask : t_reject
   task automatic t_rev();
      wr(1'b0, 13'h03e8);
      n_strobe = 0;
      n_index = 0;
      repeat (3999) enc.step(1'b1);
      settle();
      check(pos, 14'h0f9f);
      enc.step(1'b1);
      settle();
      check(pos, 14'h0000);
      check(n_strobe, 4000);
      check(n_index, 1);
      check(ipos, 14'h0000);
      check(iseen, 1'b1);
      $display("test revolution done");
   endtask : t_rev
   // double phase change, free-running zero line count and an open inverse line
   task automatic t_fault();
      wr(1'b0, 13'h0000);
      n_strobe = 0;
      n_perr = 0;
      enc.skip();
      settle();
      check(pos, 14'h0000);
      check(n_perr, 1);
      check(n_strobe, 0);
      enc.step(1'b0);
      settle();
      check(pos, 14'h3fff);
      check(fwd, 1'b0);
      diff_mode = 1'b1;
      enc.open_line(1'b1);
      settle();
      check(sfault, 1'b1);
      diff_mode = 1'b0;
      settle();
      check(sfault, 1'b0);
      enc.open_line(1'b0);
      diff_mode = 1'b1;
      settle();
      check(sfault, 1'b0);
      $display("test fault done");
   endtask : t_fault
   initial
   begin
      rst = 1'b1;
      diff_mode = 1'b1;
      setting_wr = 1'b0;
      rotation_sense_wdata = 1'b0;
      line_count_wdata = 13'h0000;
      repeat (8) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      t_reset();
      t_sense(1'b0, 1'b1);
      t_sense(1'b1, 1'b0);
      t_reject();
      t_rev();
      t_fault();
      summarize();
   end
   initial
   begin
      #1000000;
      errors++;
      summarize();
   end
endmodule : tb
